// File: rtl/amctl_defines.svh
`ifndef AMCTL_DEFINES_SVH
`define AMCTL_DEFINES_SVH

// value scale: signed tenths of a percent
`define AMCTL_MV_W          12
`define AMCTL_MV_MIN_STD    12'shFCE
`define AMCTL_MV_MIN_HC     12'shBE6
`define AMCTL_MV_MAX        12'sh41A
`define AMCTL_MV_FULL       12'sh3E8
`define AMCTL_MV_ZERO       12'sh000
`define AMCTL_MV_STEP       12'sh001

// timing
`define AMCTL_CLK_HZ        40000000
`define AMCTL_TICK_MS       1
`define AMCTL_TICK_CYC      ((`AMCTL_CLK_HZ / 1000) * `AMCTL_TICK_MS)
`define AMCTL_HOLD_ENTER_MS 3000
`define AMCTL_HOLD_EXIT_MS  1000
`define AMCTL_HOLD_FKEY_MS  1000
`define AMCTL_HOLD_INIT_MS  3000
`define AMCTL_RAMP_MS       1

// advanced level access code, -169
`define AMCTL_ADV_CODE      12'shF57

`endif

// File: rtl/amctl_pkg.sv
package amctl_pkg;

  typedef enum logic [1:0] {
    AMCTL_CTL_STD,
    AMCTL_CTL_HC,
    AMCTL_CTL_POS
  } amctl_ctl_e;

  typedef enum logic [1:0] {
    AMCTL_VALVE_CLOSE,
    AMCTL_VALVE_HOLD,
    AMCTL_VALVE_OPEN
  } amctl_valve_e;

  typedef enum logic [2:0] {
    AMCTL_SCR_OPER,
    AMCTL_SCR_SWITCH,
    AMCTL_SCR_MANUAL,
    AMCTL_SCR_INIT,
    AMCTL_SCR_ADV,
    AMCTL_SCR_OTHER
  } amctl_scr_e;

endpackage

// File: rtl/amctl_hold_timer.sv
`timescale 1ns/10ps
`include "amctl_defines.svh"

module amctl_hold_timer #(
  parameter int unsigned HOLD_MS = 1000
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic tick_i,
  input  wire logic key_i,
  output logic      done_o
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        done;
  } amctl_hold_s;

  amctl_hold_s st_q;
  amctl_hold_s st_d;

  always_comb begin
    st_d      = st_q;
    st_d.done = 1'b0;
    if (!key_i) begin
      st_d.cnt = 16'h0000; // see [RULE23]
    end else if (tick_i && st_q.cnt != 16'hFFFF) begin
      st_d.cnt = st_q.cnt + 16'h0001;
      // one pulse as the hold threshold is crossed; key must be released to rearm
      st_d.done = (st_q.cnt + 16'h0001 == 16'(HOLD_MS));
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign done_o = st_q.done;

  chk_hold_needs_key: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    done_o |-> $past(key_i)) else $error("hold done without key"); // see [RULE23]

endmodule

// File: rtl/amctl_mode_ctrl.sv
`timescale 1ns/10ps
`include "amctl_defines.svh"
// Function
// [RULE1] manual starts from last automatic output
// [RULE2] manual edits reach output at once
// [RULE3] manual only under pid control
// [RULE4] no display auto return in manual
// [RULE5] bumpless: hold old output, then ramp
// [RULE6] power loss in manual resumes manual
// [RULE7] floating/direct off: keys drive open/close
// [RULE8] pot error, no limit: 100/0 thresholds
// [RULE9] pot error, limit: match limits drive
// [RULE10] manual range by control type
// [RULE11] direct off: open, hold, close only
// [RULE12] limit enable clamps to output limits
// [RULE13] level key 3 s enters manual
// [RULE14] manual screen only; 1 s exits
// [RULE15] event input owns mode when assigned
// [RULE16] function key 1 s toggles mode
// [RULE17] manual needs select enable, default on
// [RULE18] manual beats reset; aborts autotune
// [RULE19] program timer keeps running in manual
// [RULE20] code -169 opens advanced level
// [RULE21] level key 3 s leaves operation level
// [RULE22] close/direct on: numeric manual output
// [RULE23] hold counters on millisecond tick

module amctl_mode_ctrl
  import amctl_pkg::*;
#(
  parameter int unsigned TICK_CYC = `AMCTL_TICK_CYC
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_b_i,
  input  wire logic                        level_key_i,
  input  wire logic                        function_key_i,
  input  wire logic                        up_key_i,
  input  wire logic                        down_key_i,
  input  wire logic                        manual_event_i,
  input  wire logic                        manual_event_function_i,
  input  wire logic                        function_key_am_i,
  input  wire logic                        manual_select_enable_i,
  input  wire logic                        pid_select_i,
  input  wire amctl_ctl_e                  ctl_type_i,
  input  wire logic                        floating_ctl_i,
  input  wire logic                        direct_pos_i,
  input  wire logic                        manual_limit_enable_i,
  input  wire logic                        pot_error_i,
  input  wire logic signed [`AMCTL_MV_W-1:0] mv_upper_i,
  input  wire logic signed [`AMCTL_MV_W-1:0] mv_lower_i,
  input  wire logic signed [`AMCTL_MV_W-1:0] auto_mv_i,
  input  wire logic                        retained_manual_i,
  input  wire logic signed [`AMCTL_MV_W-1:0] retained_mv_i,
  input  wire logic                        enter_code_i,
  input  wire logic signed [`AMCTL_MV_W-1:0] code_i,
  input  wire amctl_scr_e                  panel_scr_i,
  input  wire logic                        program_run_i,
  output logic                             manual_o,
  output logic signed [`AMCTL_MV_W-1:0]    process_manual_value_o,
  output logic signed [`AMCTL_MV_W-1:0]    mv_out_o,
  output amctl_valve_e                     valve_sel_o,
  output logic                             open_o,
  output logic                             close_o,
  output logic                             disp_return_en_o,
  output logic                             switch_item_vis_o,
  output amctl_scr_e                       screen_o,
  output logic                             autotune_abort_o,
  output logic                             program_timer_run_o
);

  typedef logic signed [`AMCTL_MV_W-1:0] amctl_mv_t;

  typedef struct packed {
    logic [2:0]  lvl_s;
    logic [2:0]  fk_s;
    logic [2:0]  up_s;
    logic [2:0]  dn_s;
    logic [2:0]  ev_s;
    logic [15:0] tick_cnt;
    logic        tick;
    logic        restored;
    logic        manual;
    amctl_mv_t   man_mv;
    amctl_mv_t   mv_out;
    logic        ramp;
    amctl_valve_e valve;
    logic        open;
    logic        close;
    amctl_scr_e  scr;
    logic        abort;
  } amctl_mode_s;

  amctl_mode_s st_q;
  amctl_mode_s st_d;

  logic lvl_k;
  logic fk_k;
  logic up_k;
  logic dn_k;
  logic ev_k;
  logic hold_enter;
  logic hold_exit;
  logic hold_fkey;
  logic up_edge;
  logic dn_edge;
  amctl_mv_t lo_lim;
  amctl_mv_t hi_lim;
  amctl_mv_t target;
  logic      may_manual;
  logic      go_manual;
  logic      go_auto;
  logic      valve_mode;

  // pins synchronised through the first two stages before use
  assign lvl_k = st_q.lvl_s[1];
  assign fk_k  = st_q.fk_s[1];
  assign up_k  = st_q.up_s[1];
  assign dn_k  = st_q.dn_s[1];
  assign ev_k  = st_q.ev_s[1];
  assign up_edge = st_q.up_s[1] & ~st_q.up_s[2];
  assign dn_edge = st_q.dn_s[1] & ~st_q.dn_s[2];

  amctl_hold_timer #(.HOLD_MS(`AMCTL_HOLD_ENTER_MS)) u_hold_enter (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_i  (st_q.tick),
    .key_i   (lvl_k),
    .done_o  (hold_enter)
  );

  amctl_hold_timer #(.HOLD_MS(`AMCTL_HOLD_EXIT_MS)) u_hold_exit (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_i  (st_q.tick),
    .key_i   (lvl_k),
    .done_o  (hold_exit)
  );

  amctl_hold_timer #(.HOLD_MS(`AMCTL_HOLD_FKEY_MS)) u_hold_fkey (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_i  (st_q.tick),
    .key_i   (fk_k),
    .done_o  (hold_fkey)
  );

  assign valve_mode = (ctl_type_i == AMCTL_CTL_POS) && (floating_ctl_i || !direct_pos_i);

  always_comb begin
    if (manual_limit_enable_i) begin
      lo_lim = mv_lower_i; // see [RULE12]
      hi_lim = mv_upper_i;
    end else begin
      lo_lim = (ctl_type_i == AMCTL_CTL_HC) ? `AMCTL_MV_MIN_HC : `AMCTL_MV_MIN_STD; // see [RULE10]
      hi_lim = `AMCTL_MV_MAX; // see [RULE11]
    end
  end

  // manual also needs the select enable and pid mode
  assign may_manual = pid_select_i && manual_select_enable_i; // see [RULE3] see [RULE17]

  always_comb begin
    go_manual = 1'b0;
    go_auto   = 1'b0;
    if (manual_event_function_i) begin
      go_manual = ev_k && !st_q.manual; // see [RULE15]
      go_auto   = !ev_k && st_q.manual;
    end else if (!st_q.manual) begin
      go_manual = (hold_enter && st_q.scr == AMCTL_SCR_SWITCH) || // see [RULE13]
                  (hold_fkey && function_key_am_i && st_q.scr != AMCTL_SCR_INIT &&
                   st_q.scr != AMCTL_SCR_ADV); // see [RULE16]
    end else begin
      go_auto = hold_exit || (hold_fkey && function_key_am_i); // see [RULE14]
    end
    go_manual = go_manual && may_manual;
  end

  always_comb begin
    st_d          = st_q;
    st_d.lvl_s    = {st_q.lvl_s[1:0], level_key_i};
    st_d.fk_s     = {st_q.fk_s[1:0], function_key_i};
    st_d.up_s     = {st_q.up_s[1:0], up_key_i};
    st_d.dn_s     = {st_q.dn_s[1:0], down_key_i};
    st_d.ev_s     = {st_q.ev_s[1:0], manual_event_i};
    st_d.abort    = 1'b0;
    st_d.restored = 1'b1;
    target        = st_q.manual ? st_q.man_mv : auto_mv_i;
    // ms tick for hold timers and ramp pacing
    if (st_q.tick_cnt == 16'(TICK_CYC - 1)) begin
      st_d.tick_cnt = 16'h0000; // see [RULE23]
      st_d.tick     = 1'b1;
    end else begin
      st_d.tick_cnt = st_q.tick_cnt + 16'h0001;
      st_d.tick     = 1'b0;
    end
    if (!st_q.restored && retained_manual_i && may_manual) begin
      st_d.manual = 1'b1; // see [RULE6]
      st_d.man_mv = retained_mv_i;
      st_d.mv_out = retained_mv_i;
      st_d.scr    = AMCTL_SCR_MANUAL;
    end else if (go_manual) begin
      st_d.manual = 1'b1;
      st_d.man_mv = st_q.mv_out; // see [RULE1]
      st_d.ramp   = 1'b0;
      st_d.scr    = AMCTL_SCR_MANUAL;
      st_d.abort  = 1'b1; // see [RULE18]
    end else if (go_auto) begin
      st_d.manual = 1'b0;
      st_d.ramp   = 1'b1; // see [RULE5]
      st_d.scr    = AMCTL_SCR_OPER;
    end else if (st_q.manual) begin
      st_d.scr = AMCTL_SCR_MANUAL; // see [RULE14]
      if (!valve_mode) begin
        // numeric edit, one step per key press
        if (up_edge && st_q.man_mv < hi_lim) begin
          st_d.man_mv = st_q.man_mv + `AMCTL_MV_STEP; // see [RULE22]
        end else if (dn_edge && st_q.man_mv > lo_lim) begin
          st_d.man_mv = st_q.man_mv - `AMCTL_MV_STEP;
        end
      end
      if (st_q.man_mv > hi_lim) begin
        st_d.man_mv = hi_lim; // see [RULE12]
      end else if (st_q.man_mv < lo_lim) begin
        st_d.man_mv = lo_lim;
      end
      st_d.mv_out = st_q.man_mv; // see [RULE2] see [RULE18]
    end else begin
      if (lvl_k && st_q.scr == AMCTL_SCR_OPER && hold_enter) begin
        st_d.scr = AMCTL_SCR_INIT; // see [RULE21]
      end else if (enter_code_i && code_i == `AMCTL_ADV_CODE &&
                   st_q.scr == AMCTL_SCR_INIT) begin
        st_d.scr = AMCTL_SCR_ADV; // see [RULE20]
      end else if (st_q.scr != AMCTL_SCR_INIT && st_q.scr != AMCTL_SCR_ADV) begin
        st_d.scr = panel_scr_i;
      end
      // ramp at one step per tick; no step on the switching cycle itself
      if (st_q.ramp) begin
        if (st_q.tick) begin
          if (st_q.mv_out < target) begin
            st_d.mv_out = st_q.mv_out + `AMCTL_MV_STEP; // see [RULE5]
          end else if (st_q.mv_out > target) begin
            st_d.mv_out = st_q.mv_out - `AMCTL_MV_STEP;
          end else begin
            st_d.ramp = 1'b0;
          end
        end
      end else begin
        st_d.mv_out = auto_mv_i;
      end
    end
    // valve drive
    st_d.open  = 1'b0;
    st_d.close = 1'b0;
    st_d.valve = AMCTL_VALVE_HOLD;
    if (st_q.manual && ctl_type_i == AMCTL_CTL_POS) begin
      if (pot_error_i && manual_limit_enable_i) begin
        st_d.open  = (st_q.man_mv == mv_upper_i); // see [RULE9]
        st_d.close = (st_q.man_mv == mv_lower_i);
      end else if (pot_error_i) begin
        st_d.open  = (st_q.man_mv >= `AMCTL_MV_FULL); // see [RULE8]
        st_d.close = (st_q.man_mv <= `AMCTL_MV_ZERO);
      end else if (valve_mode) begin
        st_d.open  = up_k; // see [RULE7]
        st_d.close = dn_k && !up_k;
      end
      if (valve_mode) begin
        st_d.valve = st_d.open ? AMCTL_VALVE_OPEN : // see [RULE11]
                     st_d.close ? AMCTL_VALVE_CLOSE : AMCTL_VALVE_HOLD;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q       <= '0;
      st_q.valve <= AMCTL_VALVE_HOLD;
      st_q.scr   <= AMCTL_SCR_OPER;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      disp_return_en_o    <= 1'b1;
      switch_item_vis_o   <= 1'b1;
      program_timer_run_o <= 1'b0;
    end else begin
      disp_return_en_o    <= !st_d.manual; // see [RULE4]
      switch_item_vis_o   <= !manual_event_function_i && manual_select_enable_i; // see [RULE15]
      program_timer_run_o <= program_run_i; // see [RULE19]
    end
  end

  assign manual_o               = st_q.manual;
  assign process_manual_value_o = st_q.man_mv;
  assign mv_out_o               = st_q.mv_out;
  assign valve_sel_o            = st_q.valve;
  assign open_o                 = st_q.open;
  assign close_o                = st_q.close;
  assign screen_o               = st_q.scr;
  assign autotune_abort_o       = st_q.abort;

  sequence s_enter_manual;
    $rose(manual_o);
  endsequence

  chk_manual_init_mv: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_enter_manual && $past(st_q.restored) |->
      mv_out_o == $past(mv_out_o) && process_manual_value_o == $past(mv_out_o))
    else $error("manual start not seamless"); // see [RULE1]
  chk_manual_pid_only: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_enter_manual |-> $past(pid_select_i) && $past(manual_select_enable_i))
    else $error("manual entered while not allowed"); // see [RULE3]
  chk_manual_abort_tune: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(manual_o) && $past(st_q.restored) |-> autotune_abort_o)
    else $error("autotune not aborted"); // see [RULE18]
  chk_manual_mv_follow: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    manual_o && $past(manual_o) |=> !manual_o || mv_out_o == $past(process_manual_value_o))
    else $error("manual value not applied"); // see [RULE2]
  chk_display_return: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    manual_o ##1 manual_o |-> !disp_return_en_o)
    else $error("display return in manual"); // see [RULE4]
  chk_bumpless_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $fell(manual_o) |-> mv_out_o == $past(mv_out_o))
    else $error("output stepped on switch"); // see [RULE5]
  chk_ramp_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !manual_o && $past(!manual_o) && st_q.ramp && $past(st_q.ramp) |->
      (mv_out_o - $past(mv_out_o) <= 1) && ($past(mv_out_o) - mv_out_o <= 1))
    else $error("ramp step too large"); // see [RULE5]
  chk_pot_err_open: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    manual_o && ctl_type_i == AMCTL_CTL_POS && pot_error_i && !manual_limit_enable_i &&
    process_manual_value_o >= `AMCTL_MV_FULL ##1 $stable(pot_error_i) |-> open_o)
    else $error("open not driven on pot error"); // see [RULE8]
  chk_open_close_excl: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !(open_o && close_o && !pot_error_i))
    else $error("open and close together"); // see [RULE7]
  chk_event_owns_mode: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    manual_event_function_i && $past(manual_event_function_i) && st_q.restored
      && $past(st_q.restored) |-> !$rose(manual_o) || $past(ev_k))
    else $error("mode changed without event"); // see [RULE15]

endmodule

// File: dv/amctl_panel_model.sv
`timescale 1ns/10ps

module amctl_panel_model (
  input  wire logic clk_i,
  output logic      level_key_o,
  output logic      function_key_o,
  output logic      up_key_o,
  output logic      down_key_o,
  output logic      manual_event_o
);
  initial begin
    {level_key_o, function_key_o, up_key_o, down_key_o, manual_event_o} = 5'h00;
  end

  // key 0 level, 1 function, 2 up, 3 down, 4 event
  task automatic set_key(input int key, input logic v);
    case (key)
      0: level_key_o = v;
      1: function_key_o = v;
      2: up_key_o = v;
      3: down_key_o = v;
      default: manual_event_o = v;
    endcase
  endtask

  // operator holds one key for n cycles, then lets go long enough to rearm
  task automatic hold(input int key, input int n);
    @(posedge clk_i);
    #1;
    set_key(key, 1'b1);
    repeat (n) @(posedge clk_i);
    #1;
    set_key(key, 1'b0);
    repeat (8) @(posedge clk_i);
    #1;
  endtask
endmodule

// File: dv/tb.sv
`timescale 1ns/10ps
`include "amctl_defines.svh"

module tb
  import amctl_pkg::*;
;
  localparam int TICK = 4;
  localparam int H3S  = 3000 * TICK + 40;
  localparam int H1S  = 1000 * TICK + 40;

  logic clk_i = 1'b0, rst_b_i = 1'b0;
  logic level_key_i, function_key_i, up_key_i, down_key_i, manual_event_i;
  logic manual_event_function_i = 1'b0, function_key_am_i = 1'b0, manual_select_enable_i = 1'b1;
  logic pid_select_i = 1'b1, floating_ctl_i = 1'b0, direct_pos_i = 1'b1;
  logic manual_limit_enable_i = 1'b0, pot_error_i = 1'b0, retained_manual_i = 1'b0;
  logic enter_code_i = 1'b0, program_run_i = 1'b1;
  amctl_ctl_e ctl_type_i = AMCTL_CTL_STD;
  amctl_scr_e panel_scr_i = AMCTL_SCR_OPER;
  logic signed [11:0] mv_upper_i = `AMCTL_MV_FULL, mv_lower_i = `AMCTL_MV_ZERO;
  logic signed [11:0] auto_mv_i = 12'sh000, retained_mv_i = 12'sh123, code_i = 12'sh000;
  logic manual_o, open_o, close_o, disp_return_en_o, switch_item_vis_o;
  logic autotune_abort_o, program_timer_run_o;
  logic signed [11:0] process_manual_value_o, mv_out_o, prev_mv;
  amctl_valve_e valve_sel_o;
  amctl_scr_e screen_o;
  logic [1:0] man_hist;
  int mismatches = 0, n_compared = 0, n_abort = 0, seed = 32'h012c, exp_mv, d;

  always #12.5 clk_i = ~clk_i;

  amctl_mode_ctrl #(.TICK_CYC(TICK)) DUT (.*);

  amctl_panel_model pm (
    .clk_i          (clk_i),
    .level_key_o    (level_key_i),
    .function_key_o (function_key_i),
    .up_key_o       (up_key_i),
    .down_key_o     (down_key_i),
    .manual_event_o (manual_event_i)
  );

  task automatic cmp_val(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    cmp_val({11'h000, got}, {11'h000, exp});
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk_i) begin
    if (autotune_abort_o === 1'b1)
      n_abort++;
  end

  // outside manual the applied output may only creep, never jump
  always @(posedge clk_i) begin
    d = int'(mv_out_o) - int'(prev_mv);
    if (rst_b_i && man_hist == 2'b00 && manual_o === 1'b0 && d != 0)
      cmp_flag(d <= 1 && d >= -1, 1'b1);
    prev_mv  = mv_out_o;
    man_hist = rst_b_i ? {man_hist[0], manual_o} : 2'b11;
  end

  task automatic send_code(input logic [11:0] c);
    code_i = c;
    enter_code_i = 1'b1;
    step(1);
    enter_code_i = 1'b0;
    step(4);
  endtask

  initial begin
    repeat (90000) @(posedge clk_i);
    mismatches++;
    end_of_test();
  end

  initial begin
    auto_mv_i = 12'(990 + ($random(seed) & 7));
    program_run_i = 1'($random(seed));
    step(10);
    cmp_flag(manual_o, 1'b0);
    cmp_flag(disp_return_en_o, 1'b1);
    cmp_flag(switch_item_vis_o, 1'b1);
    rst_b_i = 1'b1;
    // refused entries
    function_key_am_i = 1'b1;
    pid_select_i = 1'b0;
    pm.hold(1, H1S);
    cmp_flag(manual_o, 1'b0);
    pid_select_i = 1'b1;
    manual_select_enable_i = 1'b0;
    pm.hold(1, H1S);
    cmp_flag(manual_o, 1'b0);
    manual_select_enable_i = 1'b1;
    // function key round trip
    pm.hold(1, H1S);
    exp_mv = int'(auto_mv_i);
    cmp_flag(manual_o, 1'b1);
    cmp_val(process_manual_value_o, 12'(exp_mv));
    cmp_val({9'h000, screen_o}, {9'h000, AMCTL_SCR_MANUAL});
    cmp_flag(disp_return_en_o, 1'b0);
    cmp_val(12'(n_abort), 12'h001);
    cmp_flag(program_timer_run_o, program_run_i);
    pm.hold(1, H1S);
    cmp_flag(manual_o, 1'b0);
    function_key_am_i = 1'b0;
    // level key entry and numeric edits
    panel_scr_i = AMCTL_SCR_SWITCH;
    pm.hold(0, H3S);
    cmp_flag(manual_o, 1'b1);
    for (int i = 0; i < 4; i++) begin
      pm.hold(i == 3 ? 3 : 2, 2);
      exp_mv += (i == 3) ? -1 : 1;
    end
    cmp_val(process_manual_value_o, 12'(exp_mv));
    cmp_val(mv_out_o, 12'(exp_mv));
    // clamp, then pot error drive
    manual_limit_enable_i = 1'b1;
    mv_upper_i = 12'(exp_mv + 2);
    for (int i = 0; i < 4; i++)
      pm.hold(2, 2);
    exp_mv += 2;
    cmp_val(process_manual_value_o, 12'(exp_mv));
    ctl_type_i = AMCTL_CTL_POS;
    pot_error_i = 1'b1;
    step(4);
    cmp_flag(open_o, 1'b1);
    cmp_flag(close_o, 1'b0);
    manual_limit_enable_i = 1'b0;
    step(4);
    cmp_flag(open_o, exp_mv >= 1000);
    for (int i = 0; i < 60; i++)
      pm.hold(2, 2);
    exp_mv = (exp_mv + 60 > 1050) ? 1050 : exp_mv + 60;
    cmp_val(process_manual_value_o, 12'(exp_mv));
    cmp_flag(open_o, 1'b1);
    cmp_flag(close_o, 1'b0);
    pot_error_i = 1'b0;
    // floating valve drive from keys
    direct_pos_i = 1'b0;
    floating_ctl_i = 1'b1;
    pm.set_key(2, 1'b1);
    step(8);
    cmp_flag(open_o, 1'b1);
    cmp_flag(close_o, 1'b0);
    cmp_val({10'h000, valve_sel_o}, {10'h000, AMCTL_VALVE_OPEN});
    pm.set_key(2, 1'b0);
    pm.set_key(3, 1'b1);
    step(8);
    cmp_flag(close_o, 1'b1);
    cmp_flag(open_o, 1'b0);
    cmp_val({10'h000, valve_sel_o}, {10'h000, AMCTL_VALVE_CLOSE});
    pm.set_key(3, 1'b0);
    step(8);
    cmp_val({10'h000, valve_sel_o}, {10'h000, AMCTL_VALVE_HOLD});
    direct_pos_i = 1'b1;
    floating_ctl_i = 1'b0;
    ctl_type_i = AMCTL_CTL_STD;
    // exit and bumpless ramp back
    pm.hold(0, H1S);
    cmp_flag(manual_o, 1'b0);
    step((exp_mv - int'(auto_mv_i) + 5) * TICK);
    cmp_val(mv_out_o, auto_mv_i);
    // event input owns the mode
    manual_event_function_i = 1'b1;
    function_key_am_i = 1'b1;
    step(4);
    cmp_flag(switch_item_vis_o, 1'b0);
    pm.hold(1, H1S);
    cmp_flag(manual_o, 1'b0);
    pm.set_key(4, 1'b1);
    step(10);
    cmp_flag(manual_o, 1'b1);
    pm.set_key(4, 1'b0);
    step(10);
    cmp_flag(manual_o, 1'b0);
    manual_event_function_i = 1'b0;
    function_key_am_i = 1'b0;
    // setting levels
    panel_scr_i = AMCTL_SCR_OPER;
    pm.hold(0, H3S);
    cmp_val({9'h000, screen_o}, {9'h000, AMCTL_SCR_INIT});
    send_code(12'hF58);
    cmp_val({9'h000, screen_o}, {9'h000, AMCTL_SCR_INIT});
    send_code(`AMCTL_ADV_CODE);
    cmp_val({9'h000, screen_o}, {9'h000, AMCTL_SCR_ADV});
    // power loss while manual was retained
    retained_manual_i = 1'b1;
    rst_b_i = 1'b0;
    step(3);
    rst_b_i = 1'b1;
    step(6);
    cmp_flag(manual_o, 1'b1);
    cmp_val(process_manual_value_o, retained_mv_i);
    end_of_test();
  end
endmodule
